/* File: hdl/ccpc_clock_out.v */
/*
  Auxiliary clock output selector and integer-N PLL control registers.
  Assumes a plain register port, inputs synchronous to sys_clk, and an
  analog PLL that takes the feedback ratio and gives its oscillator level.
*/
// Summary of operation
// - Select 0h releases pin for I/O.
// - Select 1h drives PLL output clock.
// - Select 2h holds low, 3h high.
// - Select 4h drives undivided crystal clock.
// - Selects 5h-7h drive crystal /2, /4, /8.
// - Selects 8h-Bh toggle on timer overflows.
// - Clock drives pin only while enable set.
// - Feedback codes 00 and 11 divide by 23.
// - Code 01 divides by 27, 10 by 28.
// - Feedback field sits in control bits 1:0.
// - Output divider: full byte at 3Eh.
// - Divider 8-254 divides exactly; 0-7 and 255 reserved.
// - PLL clock is crystal times FB/2/div.
// - Pin I/O enable switches clock output off.
`timescale 1ns/10ps
`default_nettype none
`include "ccpc_consts.vh"

module ccpc_clock_out #(
  parameter DIV_W = 8,
  parameter FB_W = 5,
  parameter TIMERS = 4
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rd_data,
  // Clock sources.
  input wire xtal_clk,
  input wire pll_osc_clk,
  input wire [TIMERS-1:0] timer_overflow,
  // Analog PLL control.
  output wire pll_power_down,
  output reg [FB_W-1:0] pll_feedback_ratio,
  output wire [DIV_W-1:0] pll_output_divider_factor,
  // Auxiliary clock pin.
  input wire aux_clock_pin_in,
  output reg aux_clock_pin_out,
  output reg aux_clock_pin_oe_n
);

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  reg [7:0] ctrl;
  reg [DIV_W-1:0] out_div;
  reg aux_pin_gpio_output_enable;
  reg aux_pin_gpio_level;

  wire [3:0] aux_clock_source_select;
  wire aux_clock_output_enable;
  wire [1:0] pll_feedback_divider;

  // Fields of the control register.
  assign aux_clock_source_select = ctrl[`CCPC_SEL_HI:`CCPC_SEL_LO];
  assign aux_clock_output_enable = ctrl[`CCPC_CLK_EN_BIT];
  assign pll_power_down = ctrl[`CCPC_PD_BIT];
  assign pll_feedback_divider = ctrl[`CCPC_FB_HI:`CCPC_FB_LO];
  assign pll_output_divider_factor = out_div;

  // Writes land at the next edge; unmapped addresses are ignored.
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= `CCPC_RST_CTRL;
      out_div <= `CCPC_RST_OUT_DIV;
      aux_pin_gpio_output_enable <= `CCPC_RST_PIN;
      aux_pin_gpio_level <= `CCPC_RST_PIN;
    end else if (reg_wr) begin
      case (reg_addr)
        `CCPC_ADDR_CTRL: begin
          ctrl <= reg_wr_data;
        end
        `CCPC_ADDR_OUT_DIV: begin
          out_div <= reg_wr_data[DIV_W-1:0];
        end
        `CCPC_ADDR_PIN_EN: begin
          aux_pin_gpio_output_enable <= reg_wr_data[`CCPC_PIN_BIT];
        end
        `CCPC_ADDR_PIN_OUT: begin
          aux_pin_gpio_level <= reg_wr_data[`CCPC_PIN_BIT];
        end
        default: begin
          ctrl <= ctrl;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Feedback divider decode
  // ----------------------------------------------------------------------
  // The ratio is registered so the analog side never sees a decode glitch.
  always @(posedge sys_clk) begin
    if (rst) begin
      pll_feedback_ratio <= `CCPC_FB_RATIO_23;
    end else begin
      case (pll_feedback_divider)
        `CCPC_FB_ENC_27: begin
          pll_feedback_ratio <= `CCPC_FB_RATIO_27;
        end
        `CCPC_FB_ENC_28: begin
          pll_feedback_ratio <= `CCPC_FB_RATIO_28;
        end
        default: begin
          pll_feedback_ratio <= `CCPC_FB_RATIO_23;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // PLL output divider
  // ----------------------------------------------------------------------
  // The analog oscillator already runs at crystal times ratio over two;
  // this stage divides it by the output factor to form the PLL clock.
  reg osc_q;
  reg [DIV_W-1:0] div_cnt;
  reg pll_clk_out;
  wire osc_rise;
  wire div_reserved;
  wire [DIV_W-1:0] div_half;

  assign osc_rise = pll_osc_clk & ~osc_q;
  assign div_reserved = (out_div < `CCPC_OUT_DIV_MIN) ||
                        (out_div > `CCPC_OUT_DIV_MAX);
  assign div_half = out_div >> 1;

  // Count oscillator edges 0..N-1; high for the first half of each period.
  // Odd factors give a period of exactly N with a one-edge duty skew.
  always @(posedge sys_clk) begin
    if (rst) begin
      osc_q <= 1'h0;
      div_cnt <= {DIV_W{1'b0}};
      pll_clk_out <= 1'h0;
    end else begin
      osc_q <= pll_osc_clk;
      if (pll_power_down || div_reserved) begin
        div_cnt <= {DIV_W{1'b0}};
        pll_clk_out <= 1'h0;
      end else if (osc_rise) begin
        if (div_cnt >= out_div - 1'b1) begin
          div_cnt <= {DIV_W{1'b0}};
        end else begin
          div_cnt <= div_cnt + 1'b1;
        end
        pll_clk_out <= (div_cnt + 1'b1 < div_half) ||
                       (div_cnt >= out_div - 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Crystal divisions
  // ----------------------------------------------------------------------
  wire xtal_q;
  wire [2:0] xtal_div;

  ccpc_xtal_div #(
    .STAGES(3)
  ) u_xtal_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .xtal_clk(xtal_clk),
    .xtal_q(xtal_q),
    .xtal_div(xtal_div)
  );

  // ----------------------------------------------------------------------
  // Timer overflow toggles
  // ----------------------------------------------------------------------
  // Only the selected timer toggles its flop, so the pin starts from the
  // level last left rather than jumping when the source changes.
  wire [TIMERS-1:0] timer_toggle;

  genvar t;
  generate
    for (t = 0; t < TIMERS; t = t + 1) begin : g_timer
      reg level;
      assign timer_toggle[t] = level;
      always @(posedge sys_clk) begin
        if (rst) begin
          level <= 1'h0;
        end else if (timer_overflow[t] &&
                     aux_clock_source_select == `CCPC_SEL_TMR0 + t) begin
          level <= ~level;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Source select
  // ----------------------------------------------------------------------
  reg next_src_level;
  reg next_src_valid;

  // Pick the source level; reserved codes and 0h drive nothing.
  always @* begin
    next_src_level = 1'b0;
    next_src_valid = 1'b1;
    case (aux_clock_source_select)
      `CCPC_SEL_GPIO: begin
        next_src_valid = 1'b0;
      end
      `CCPC_SEL_PLL: begin
        next_src_level = pll_clk_out;
      end
      `CCPC_SEL_LOW: begin
        next_src_level = 1'b0;
      end
      `CCPC_SEL_HIGH: begin
        next_src_level = 1'b1;
      end
      `CCPC_SEL_XTAL: begin
        next_src_level = xtal_q;
      end
      `CCPC_SEL_XTAL2: begin
        next_src_level = xtal_div[0];
      end
      `CCPC_SEL_XTAL4: begin
        next_src_level = xtal_div[1];
      end
      `CCPC_SEL_XTAL8: begin
        next_src_level = xtal_div[2];
      end
      `CCPC_SEL_TMR0: begin
        next_src_level = timer_toggle[0];
      end
      `CCPC_SEL_TMR1: begin
        next_src_level = timer_toggle[1];
      end
      `CCPC_SEL_TMR2: begin
        next_src_level = timer_toggle[2];
      end
      `CCPC_SEL_TMR3: begin
        next_src_level = timer_toggle[3];
      end
      default: begin
        next_src_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------------
  // General output use wins over every clock source; otherwise the clock
  // reaches the pin only while the output enable is set.
  always @(posedge sys_clk) begin
    if (rst) begin
      aux_clock_pin_out <= 1'h0;
      aux_clock_pin_oe_n <= 1'h1;
    end else if (aux_pin_gpio_output_enable) begin
      aux_clock_pin_out <= aux_pin_gpio_level;
      aux_clock_pin_oe_n <= 1'h0;
    end else if (aux_clock_output_enable && next_src_valid) begin
      aux_clock_pin_out <= next_src_level;
      aux_clock_pin_oe_n <= 1'h0;
    end else begin
      aux_clock_pin_out <= 1'h0;
      aux_clock_pin_oe_n <= 1'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  reg [7:0] next_rd_data;

  // Read data stand for exactly the cycle after the strobe.
  always @* begin
    next_rd_data = 8'h00;
    case (reg_addr)
      `CCPC_ADDR_CTRL: begin
        next_rd_data = ctrl;
      end
      `CCPC_ADDR_OUT_DIV: begin
        next_rd_data = out_div;
      end
      `CCPC_ADDR_PIN_EN: begin
        next_rd_data[`CCPC_PIN_BIT] = aux_pin_gpio_output_enable;
      end
      `CCPC_ADDR_PIN_OUT: begin
        next_rd_data[`CCPC_PIN_BIT] = aux_pin_gpio_level;
      end
      `CCPC_ADDR_STATUS: begin
        next_rd_data[`CCPC_ST_PIN_BIT] = aux_clock_pin_in;
        next_rd_data[`CCPC_ST_RSV_BIT] = div_reserved;
        next_rd_data[`CCPC_ST_PLL_BIT] = ~pll_power_down & ~div_reserved;
        next_rd_data[`CCPC_ST_DRV_BIT] = ~aux_clock_pin_oe_n;
      end
      default: begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd) begin
      reg_rd_data <= next_rd_data;
    end else begin
      reg_rd_data <= 8'h00;
    end
  end

endmodule // ccpc_clock_out

`default_nettype wire

/* File: hdl/ccpc_consts.vh */
/*
  Constants of the auxiliary clock output and PLL configuration block:
  register addresses, field positions, select codes, divider figures and
  reset values.
  Assumes it is included by bare name from the design files that need it.
*/
`ifndef CCPC_CONSTS_VH
`define CCPC_CONSTS_VH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define CCPC_ADDR_CTRL 8'h3D
`define CCPC_ADDR_OUT_DIV 8'h3E
`define CCPC_ADDR_PIN_EN 8'h44
`define CCPC_ADDR_PIN_OUT 8'h45
`define CCPC_ADDR_STATUS 8'h4F

// ----------------------------------------------------------------------
// Field positions of the control register
// ----------------------------------------------------------------------
`define CCPC_SEL_HI 7
`define CCPC_SEL_LO 4
`define CCPC_CLK_EN_BIT 3
`define CCPC_PD_BIT 2
`define CCPC_FB_HI 1
`define CCPC_FB_LO 0

// Pin enable and pin output registers share this bit position.
`define CCPC_PIN_BIT 6

// Status register bit positions.
`define CCPC_ST_PIN_BIT 0
`define CCPC_ST_RSV_BIT 1
`define CCPC_ST_PLL_BIT 2
`define CCPC_ST_DRV_BIT 3

// ----------------------------------------------------------------------
// Clock source select codes
// ----------------------------------------------------------------------
`define CCPC_SEL_GPIO 4'h0
`define CCPC_SEL_PLL 4'h1
`define CCPC_SEL_LOW 4'h2
`define CCPC_SEL_HIGH 4'h3
`define CCPC_SEL_XTAL 4'h4
`define CCPC_SEL_XTAL2 4'h5
`define CCPC_SEL_XTAL4 4'h6
`define CCPC_SEL_XTAL8 4'h7
`define CCPC_SEL_TMR0 4'h8
`define CCPC_SEL_TMR1 4'h9
`define CCPC_SEL_TMR2 4'hA
`define CCPC_SEL_TMR3 4'hB

// ----------------------------------------------------------------------
// Feedback divider encodings and ratios
// ----------------------------------------------------------------------
`define CCPC_FB_ENC_27 2'h1
`define CCPC_FB_ENC_28 2'h2
`define CCPC_FB_RATIO_23 5'h17
`define CCPC_FB_RATIO_27 5'h1B
`define CCPC_FB_RATIO_28 5'h1C

// ----------------------------------------------------------------------
// Output divider limits and reset values
// ----------------------------------------------------------------------
`define CCPC_OUT_DIV_MIN 8'h08
`define CCPC_OUT_DIV_MAX 8'hFE
`define CCPC_RST_CTRL 8'h00
`define CCPC_RST_OUT_DIV 8'h08
`define CCPC_RST_PIN 1'h0

`endif

/* File: hdl/ccpc_xtal_div.v */
/*
  Binary divider of the crystal clock: gives the crystal level and its
  divisions by 2, 4 and 8, all from flip-flops.
  Assumes xtal_clk is a level synchronous to sys_clk, as all pin inputs.
*/
`timescale 1ns/10ps
`default_nettype none

module ccpc_xtal_div #(
  parameter STAGES = 3
) (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Crystal level in.
  input wire xtal_clk,
  // Crystal copy and divided levels out.
  output reg xtal_q,
  output wire [STAGES-1:0] xtal_div
);

  // ----------------------------------------------------------------------
  // Stage chain
  // ----------------------------------------------------------------------
  wire [STAGES:0] stage_rise;

  // Each stage toggles on the falling edge of the one before it; the first on a crystal rise.
  assign stage_rise[0] = xtal_clk & ~xtal_q;

  // Registered crystal copy, used for the first edge detect.
  always @(posedge sys_clk) begin
    if (rst) begin
      xtal_q <= 1'h0;
    end else begin
      xtal_q <= xtal_clk;
    end
  end

  // One toggle flop per division stage; a carry ripples as in a counter.
  genvar g;
  generate
    for (g = 0; g < STAGES; g = g + 1) begin : g_stage
      reg half;
      assign xtal_div[g] = half;
      assign stage_rise[g+1] = stage_rise[g] & half;
      always @(posedge sys_clk) begin
        if (rst) begin
          half <= 1'h0;
        end else if (stage_rise[g]) begin
          half <= ~half;
        end
      end
    end
  endgenerate

endmodule // ccpc_xtal_div

`default_nettype wire

/* File: bench/ccpc_clock_out_assertions.sv */
/* Checker of the clock output block: register writes, read timing, pin.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module ccpc_chk (
  // Clock and reset.
  input wire sys_clk,
  input wire rst,
  // Register port.
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rd_data,
  // Sources, PLL control and pin.
  input wire xtal_clk,
  input wire [3:0] timer_overflow,
  input wire pll_power_down,
  input wire [4:0] pll_feedback_ratio,
  input wire [7:0] pll_output_divider_factor,
  input wire aux_clock_pin_out,
  input wire aux_clock_pin_oe_n
);
  reg [7:0] ctrl;
  reg pen;
  reg plvl;
  wire drv = ctrl[3] && !pen;
  function [4:0] fb_ratio(input [1:0] e);
    fb_ratio = (e == 2'h1) ? 5'd27 : (e == 2'h2) ? 5'd28 : 5'd23;
  endfunction
  // Shadow registers; the pin lags them by one cycle, so they lead it.
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl <= 8'h00;
      pen <= 1'b0;
      plvl <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h3D) ctrl <= reg_wr_data;
      if (reg_addr == 8'h44) pen <= reg_wr_data[6];
      if (reg_addr == 8'h45) plvl <= reg_wr_data[6];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_fb_ratio: assert property (reg_wr && reg_addr == 8'h3D |=> ##1
    pll_feedback_ratio == fb_ratio($past(reg_wr_data[1:0], 2)))
    else $error("feedback ratio wrong");
  a_div_write: assert property (reg_wr && reg_addr == 8'h3E |=>
    pll_output_divider_factor == $past(reg_wr_data))
    else $error("divider write lost");
  a_pd_follow: assert property (reg_wr && reg_addr == 8'h3D |=>
    pll_power_down == $past(reg_wr_data[2]))
    else $error("power down wrong");
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rd_data == 8'h00)
    else $error("read data not idle");
  a_rd_div: assert property (reg_rd && reg_addr == 8'h3E |=>
    reg_rd_data == $past(pll_output_divider_factor))
    else $error("divider read wrong");
  a_pin_free: assert property (!pen && (ctrl[7:4] == 4'h0 || !ctrl[3])
    |=> aux_clock_pin_oe_n) else $error("pin not released");
  a_pin_gpio: assert property (pen |=> !aux_clock_pin_oe_n &&
    aux_clock_pin_out == $past(plvl)) else $error("pin level wrong");
  a_pin_level: assert property (drv && ctrl[7:5] == 3'h1 |=>
    !aux_clock_pin_oe_n && aux_clock_pin_out == $past(ctrl[4]))
    else $error("static level wrong");
  a_xtal_pass: assert property ((drv && ctrl[7:4] == 4'h4)[*2] |=>
    aux_clock_pin_out == $past(xtal_clk, 2)) else $error("crystal wrong");
  a_tmr_toggle: assert property (drv && ctrl[7:4] == 4'h8 &&
    timer_overflow[0] ##1 drv && ctrl[7:4] == 4'h8 |=>
    aux_clock_pin_out != $past(aux_clock_pin_out))
    else $error("timer toggle missing");
  a_pd_low: assert property ((drv && ctrl[7:2] == 6'h07)[*2] |=>
    !aux_clock_pin_out) else $error("stopped PLL still clocks");
  c_pll: cover property (drv && ctrl[7:4] == 4'h1 && $rose(aux_clock_pin_out));
  c_tmr: cover property (drv && ctrl[7:4] == 4'hB && timer_overflow[3]);
  c_gpio: cover property (pen && aux_clock_pin_out);
endmodule // ccpc_chk
bind ccpc_clock_out ccpc_chk i_ccpc_chk (.sys_clk, .rst, .reg_addr,
  .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .xtal_clk, .timer_overflow,
  .pll_power_down, .pll_feedback_ratio, .pll_output_divider_factor,
  .aux_clock_pin_out, .aux_clock_pin_oe_n);
`default_nettype wire

/* File: bench/testbench.sv */
/* Self-checking bench of the clock output block.
   Assumes the checker is bound; crystal and PLL levels toggle every cycle. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic xtal_clk = 1'b0;
  logic pll_osc_clk = 1'b0;
  logic [3:0] timer_overflow = 4'h0;
  wire [7:0] reg_rd_data;
  wire pll_power_down;
  wire [4:0] pll_feedback_ratio;
  wire [7:0] pll_output_divider_factor;
  wire aux_clock_pin_out;
  wire aux_clock_pin_oe_n;
  // A released pin is pulled high.
  wire aux_clock_pin_in = aux_clock_pin_oe_n | aux_clock_pin_out;
  integer fail_count = 0;
  integer checks_done = 0;
  integer cycles = 0;
  integer p;
  ccpc_clock_out i_ccpc_clock_out (.sys_clk, .rst, .reg_addr, .reg_wr_data,
    .reg_wr, .reg_rd, .reg_rd_data, .xtal_clk, .pll_osc_clk, .timer_overflow,
    .pll_power_down, .pll_feedback_ratio, .pll_output_divider_factor,
    .aux_clock_pin_in, .aux_clock_pin_out, .aux_clock_pin_oe_n);
  always #20 sys_clk = ~sys_clk;
  // Sources toggle each cycle so every edge is resolvable at 25 MHz.
  always @(posedge sys_clk) begin
    xtal_clk <= ~xtal_clk;
    pll_osc_clk <= ~pll_osc_clk;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rd_data, e, nm);
  endtask
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // Cycles from one rising edge of the pin to the next. The first sample
  // waits one edge, so a level left by the old source is never taken as
  // the start of a period of the new one.
  task period;
    tick(1);
    p = 0;
    for (int i = 0; i < 2; i++) begin
      if (i == 1) begin
        p = 0;
      end
      while (aux_clock_pin_out !== 1'b0) begin
        tick(1);
        p++;
      end
      while (aux_clock_pin_out !== 1'b1) begin
        tick(1);
        p++;
      end
    end
  endtask
  // Counts high samples of the pin over 40 cycles.
  task quiet;
    tick(3);
    p = 0;
    repeat (40) begin tick(1); p += aux_clock_pin_out; end
  endtask
  task t_basic;
    logic [4:0] ratio [0:3] = '{5'd23, 5'd27, 5'd28, 5'd23};
    rd(8'h3E, 8'h08, "divider reset");
    rd(8'h50, 8'h00, "unmapped read");
    chk(aux_clock_pin_oe_n, 1'b1, "pin oe_n");
    for (int e = 0; e < 4; e++) begin
      wr(8'h3D, e[7:0]);
      tick(2);
      chk(pll_feedback_ratio, ratio[e], "ratio");
      rd(8'h3D, e[7:0], "feedback field");
    end
    wr(8'h3E, 8'hFE);
    rd(8'h3E, 8'hFE, "divider");
  endtask
  task t_levels;
    logic [7:0] cv [0:4] = '{8'h08, 8'h28, 8'h38, 8'h30, 8'hC8};
    logic [1:0] pv [0:4] = '{2'b10, 2'b00, 2'b01, 2'b10, 2'b10};
    for (int k = 0; k < 5; k++) begin
      wr(8'h3D, cv[k]);
      tick(2);
      chk({aux_clock_pin_oe_n, aux_clock_pin_out}, pv[k], "pin");
    end
  endtask
  task t_clocks;
    logic [7:0] dv [0:2] = '{8'd8, 8'd9, 8'd254};
    for (int s = 4; s < 8; s++) begin
      wr(8'h3D, {s[3:0], 4'h8});
      period;
      chk(p, 16'd2 << (s - 4), "crystal period");
    end
    wr(8'h3D, 8'h18);
    for (int k = 0; k < 3; k++) begin
      wr(8'h3E, dv[k]);
      period;
      period;
      chk(p, 16'd2 * dv[k], "PLL period");
    end
    wr(8'h3D, 8'h1C);
    quiet;
    chk(pll_power_down, 1'b1, "power down");
    chk(p, 16'd0, "stopped PLL pin");
    wr(8'h3D, 8'h18);
    wr(8'h3E, 8'hFF);
    quiet;
    chk(p, 16'd0, "reserved divider pin");
  endtask
  task pulse(input logic [3:0] m);
    @(posedge sys_clk);
    timer_overflow <= m;
    @(posedge sys_clk);
    timer_overflow <= 4'h0;
    tick(1);
  endtask
  task t_timer;
    logic p0;
    for (int t = 0; t < 4; t++) begin
      wr(8'h3D, {4'h8 + t[3:0], 4'h8});
      tick(3);
      p0 = aux_clock_pin_out;
      pulse(4'h1 << t);
      chk(aux_clock_pin_out, !p0, "timer toggle");
      pulse(4'h1 << ((t + 1) % 4));
      chk(aux_clock_pin_out, !p0, "other timer");
    end
  endtask
  task t_gpio;
    wr(8'h3D, 8'h38);
    wr(8'h44, 8'h40);
    tick(2);
    chk({aux_clock_pin_oe_n, aux_clock_pin_out}, 2'b00, "gpio low");
    wr(8'h45, 8'h40);
    tick(2);
    chk({aux_clock_pin_oe_n, aux_clock_pin_out}, 2'b01, "gpio high");
    rd(8'h44, 8'h40, "pin enable");
    rd(8'h4F, 8'h0B, "status");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    t_basic;
    t_levels;
    t_clocks;
    t_timer;
    t_gpio;
    final_report;
  end
endmodule // testbench
`default_nettype wire
